// ===== rtl/lcr_pkg.sv
// Package: offsets, reset values, field positions and carriers of the bank
package lcr_pkg;
  // Register offsets
  localparam logic [7:0] GREEN_PWM_DUTY_ADDR = 8'h03;
  localparam logic [7:0] BLUE_PWM_DUTY_ADDR = 8'h04;
  localparam logic [7:0] RED_LED_CURRENT_ADDR = 8'h05;
  localparam logic [7:0] GREEN_LED_CURRENT_ADDR = 8'h06;
  localparam logic [7:0] BLUE_LED_CURRENT_ADDR = 8'h07;
  localparam logic [7:0] DRIVER_CONFIGURATION_ADDR = 8'h08;
  localparam logic [7:0] RED_PROGRAM_COUNTER_ADDR = 8'h09;
  // Reset values
  localparam logic [7:0] PWM_DUTY_RESET = 8'h00;
  localparam logic [7:0] LED_CURRENT_RESET = 8'haf;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [3:0] PC_RESET = 4'h0;
  // Configuration field positions
  localparam int CFG_FAST_PWM_BIT = 6;
  localparam int CFG_POWER_SAVE_BIT = 5;
  localparam int CFG_PUMP_MSB = 4;
  localparam int CFG_PUMP_LSB = 3;
  localparam int CFG_RED_SUPPLY_BIT = 2;
  localparam int CFG_CLK_SRC_MSB = 1;
  localparam int CFG_CLK_SRC_LSB = 0;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h7f;
  localparam int PC_WIDTH = 4;
  // Current step per code in microamps
  localparam int CURRENT_STEP_UA = 100;
  // Mode and control codes
  localparam logic [1:0] MODE_DIRECT = 2'b11;
  localparam logic [1:0] SEQUENCER_RUN_CONTROL_HOLD = 2'b00;
  localparam logic [1:0] PUMP_OFF = 2'b00;
  localparam logic [1:0] PUMP_BYPASS = 2'b01;
  localparam logic [1:0] PUMP_GAIN = 2'b10;
  localparam logic [1:0] PUMP_AUTO = 2'b11;
  localparam logic [1:0] CLK_SRC_EXT = 2'b00;
  localparam logic [1:0] CLK_SRC_AUTO = 2'b10;
  // Timing
  localparam int CLK_HZ = 100000000;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int FAST_PWM_HZ = 558;
  localparam int PWM_STEPS = 256;
  localparam int INT_SLOW_DIV = CLK_HZ / SLOW_CLK_HZ;
  localparam int FAST_STEP_DIV = CLK_HZ / (FAST_PWM_HZ * PWM_STEPS);
  localparam int EXT_LOSS_TICKS = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_req_type;

  typedef struct packed {
    logic pump_enable;
    logic pump_bypass;
    logic pump_gain;
    logic pump_auto;
    logic power_saving_enable;
    logic red_supply_select;
    logic ext_clock_used;
  } lcr_ctrl_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } lcr_current_type;
endpackage : lcr_pkg

// ===== rtl/lcr_regs.sv
// LED channel register bank with PWM timing and slow-clock handover
`timescale 1ns/1ns
module lcr_regs #(
  parameter int INT_DIV = lcr_pkg::INT_SLOW_DIV,
  parameter int FAST_DIV = lcr_pkg::FAST_STEP_DIV
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire lcr_pkg::lcr_req_type req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic slow_clock_input,
  input wire logic [1:0] green_mode,
  input wire logic [1:0] blue_mode,
  input wire logic [1:0] red_sequencer_run_control,
  input wire logic [7:0] green_seq_level,
  input wire logic [7:0] blue_seq_level,
  output logic [7:0] green_pwm_level,
  output logic [7:0] blue_pwm_level,
  output logic green_pwm_out,
  output logic blue_pwm_out,
  output lcr_pkg::lcr_current_type current_code,
  output lcr_pkg::lcr_ctrl_type ctrl,
  output logic seq_tick,
  output logic [3:0] red_program_counter,
  output logic red_pc_load
);
  import lcr_pkg::*;

  // Register state
  logic [7:0] green_pwm_duty_r, green_pwm_duty_nxt;
  logic [7:0] blue_pwm_duty_r, blue_pwm_duty_nxt;
  lcr_current_type current_r, current_nxt;
  logic [7:0] config_r, config_nxt;
  logic [PC_WIDTH-1:0] pc_r, pc_nxt;
  logic pc_pend_r, pc_pend_nxt;
  logic [PC_WIDTH-1:0] pc_seq_r, pc_seq_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  // Timing state
  logic sync1_r, sync2_r, sync3_r;
  logic [11:0] int_cnt_r, int_cnt_nxt;
  logic [9:0] fast_cnt_r, fast_cnt_nxt;
  logic [2:0] loss_cnt_r, loss_cnt_nxt;
  logic ext_used_r, ext_used_nxt;
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt;
  logic green_out_r, green_out_nxt;
  logic blue_out_r, blue_out_nxt;
  logic [7:0] green_lvl_r, green_lvl_nxt;
  logic [7:0] blue_lvl_r, blue_lvl_nxt;
  logic [2:0] fill_r;
  lcr_ctrl_type ctrl_r, ctrl_nxt;

  logic in_hold;
  logic ext_edge;
  logic int_tick;
  logic fast_tick;
  logic slow_tick;
  logic pwm_step;
  logic [1:0] clk_src;
  logic ext_rise;
  logic [1:0] pump_nxt;

  // Hold test, shared by counter read and write paths
  function automatic logic is_hold(input logic [1:0] code);
    return code == SEQUENCER_RUN_CONTROL_HOLD;
  endfunction : is_hold

  // Duty compare, used for both colour channels
  function automatic logic pwm_high(input logic [7:0] lvl,
                                    input logic [7:0] cnt);
    return cnt < lvl;
  endfunction : pwm_high

  assign in_hold = is_hold(red_sequencer_run_control);
  assign clk_src = config_r[CFG_CLK_SRC_MSB:CFG_CLK_SRC_LSB];
  // Both edges of the slow clock pace the 256 Hz PWM frame; edges count
  // only once the pin has filled all three stages, so a pin that is
  // already high at reset release gives no false edge
  assign ext_edge = fill_r[2] & (sync2_r ^ sync3_r);
  assign ext_rise = fill_r[2] & sync2_r & ~sync3_r;
  assign int_tick = int_cnt_r == 12'(INT_DIV - 1);
  assign fast_tick = fast_cnt_r == 10'(FAST_DIV - 1);
  // Only rising edges count as sequencer clock ticks
  assign slow_tick = ext_used_r ? ext_rise : int_tick;
  assign pwm_step = config_r[CFG_FAST_PWM_BIT] ? fast_tick : ext_edge;

  // Slow clock pin synchroniser; the third stage feeds edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      fill_r <= 3'h0;
    end else begin
      sync1_r <= slow_clock_input;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // Clock source choice and internal dividers
  always_comb begin
    int_cnt_nxt = int_tick ? 12'h000 : int_cnt_r + 12'h001;
    fast_cnt_nxt = fast_tick ? 10'h000 : fast_cnt_r + 10'h001;
    loss_cnt_nxt = loss_cnt_r;
    if (ext_edge) begin
      loss_cnt_nxt = 3'h0;
    end else if (int_tick && loss_cnt_r != 3'(EXT_LOSS_TICKS)) begin
      loss_cnt_nxt = loss_cnt_r + 3'h1;
    end
    // Auto mode falls back once external edges stop for a few periods
    unique case (clk_src)
      CLK_SRC_EXT: ext_used_nxt = 1'b1;
      CLK_SRC_AUTO: ext_used_nxt = loss_cnt_r != 3'(EXT_LOSS_TICKS);
      default: ext_used_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      int_cnt_r <= 12'h000;
      fast_cnt_r <= 10'h000;
      loss_cnt_r <= 3'(EXT_LOSS_TICKS);
      ext_used_r <= 1'b1;
    end else begin
      int_cnt_r <= int_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      ext_used_r <= ext_used_nxt;
    end
  end

  // PWM counter and outputs; level changes only at frame start to avoid
  // glitched duty when the register is written mid-frame
  always_comb begin
    pwm_cnt_nxt = pwm_cnt_r;
    green_lvl_nxt = green_lvl_r;
    blue_lvl_nxt = blue_lvl_r;
    green_out_nxt = green_out_r;
    blue_out_nxt = blue_out_r;
    if (pwm_step) begin
      pwm_cnt_nxt = pwm_cnt_r + 8'h01;
      if (pwm_cnt_r == 8'hff) begin
        green_lvl_nxt = (green_mode == MODE_DIRECT) ?
                        green_pwm_duty_r : green_seq_level;
        blue_lvl_nxt = (blue_mode == MODE_DIRECT) ?
                       blue_pwm_duty_r : blue_seq_level;
      end
      green_out_nxt = pwm_high(green_lvl_nxt, pwm_cnt_nxt);
      blue_out_nxt = pwm_high(blue_lvl_nxt, pwm_cnt_nxt);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt_r <= 8'h00;
      green_lvl_r <= PWM_DUTY_RESET;
      blue_lvl_r <= PWM_DUTY_RESET;
      green_out_r <= 1'b0;
      blue_out_r <= 1'b0;
    end else begin
      pwm_cnt_r <= pwm_cnt_nxt;
      green_lvl_r <= green_lvl_nxt;
      blue_lvl_r <= blue_lvl_nxt;
      green_out_r <= green_out_nxt;
      blue_out_r <= blue_out_nxt;
    end
  end

  // Register writes, reads and counter handover
  always_comb begin
    green_pwm_duty_nxt = green_pwm_duty_r;
    blue_pwm_duty_nxt = blue_pwm_duty_r;
    current_nxt = current_r;
    config_nxt = config_r;
    pc_nxt = pc_r;
    pc_pend_nxt = pc_pend_r;
    pc_seq_nxt = pc_seq_r;
    pc_load_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    // Pending counter value moves over on the next slow tick
    if (pc_pend_r && slow_tick) begin
      pc_seq_nxt = pc_r;
      pc_load_nxt = 1'b1;
      pc_pend_nxt = 1'b0;
    end
    if (req.wr) begin
      unique case (req.addr)
        GREEN_PWM_DUTY_ADDR: green_pwm_duty_nxt = req.wdata;
        BLUE_PWM_DUTY_ADDR: blue_pwm_duty_nxt = req.wdata;
        RED_LED_CURRENT_ADDR: current_nxt.red = req.wdata;
        GREEN_LED_CURRENT_ADDR: current_nxt.green = req.wdata;
        BLUE_LED_CURRENT_ADDR: current_nxt.blue = req.wdata;
        DRIVER_CONFIGURATION_ADDR:
          config_nxt = req.wdata & CONFIG_WRITE_MASK;
        RED_PROGRAM_COUNTER_ADDR: begin
          if (in_hold) begin
            pc_nxt = req.wdata[PC_WIDTH-1:0];
            pc_pend_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      rvalid_nxt = 1'b1;
      unique case (req.addr)
        GREEN_PWM_DUTY_ADDR: rdata_nxt = green_pwm_duty_r;
        BLUE_PWM_DUTY_ADDR: rdata_nxt = blue_pwm_duty_r;
        RED_LED_CURRENT_ADDR: rdata_nxt = current_r.red;
        GREEN_LED_CURRENT_ADDR: rdata_nxt = current_r.green;
        BLUE_LED_CURRENT_ADDR: rdata_nxt = current_r.blue;
        DRIVER_CONFIGURATION_ADDR: rdata_nxt = config_r;
        RED_PROGRAM_COUNTER_ADDR:
          rdata_nxt = in_hold ? {4'h0, pc_r} : 8'h00;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      green_pwm_duty_r <= PWM_DUTY_RESET;
      blue_pwm_duty_r <= PWM_DUTY_RESET;
      current_r <= {3{LED_CURRENT_RESET}};
      config_r <= CONFIG_RESET;
      pc_r <= PC_RESET;
      pc_pend_r <= 1'b0;
      pc_seq_r <= PC_RESET;
      pc_load_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      green_pwm_duty_r <= green_pwm_duty_nxt;
      blue_pwm_duty_r <= blue_pwm_duty_nxt;
      current_r <= current_nxt;
      config_r <= config_nxt;
      pc_r <= pc_nxt;
      pc_pend_r <= pc_pend_nxt;
      pc_seq_r <= pc_seq_nxt;
      pc_load_r <= pc_load_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Control decode from the next configuration value, so the registered
  // outputs move on the same edge as the register they mirror
  assign pump_nxt = config_nxt[CFG_PUMP_MSB:CFG_PUMP_LSB];
  always_comb begin
    ctrl_nxt.pump_enable = pump_nxt != PUMP_OFF;
    ctrl_nxt.pump_bypass = pump_nxt == PUMP_BYPASS;
    ctrl_nxt.pump_gain = pump_nxt == PUMP_GAIN;
    ctrl_nxt.pump_auto = pump_nxt == PUMP_AUTO;
    ctrl_nxt.power_saving_enable = config_nxt[CFG_POWER_SAVE_BIT];
    ctrl_nxt.red_supply_select = config_nxt[CFG_RED_SUPPLY_BIT];
    ctrl_nxt.ext_clock_used = ext_used_nxt;
  end

  // Reset value is the decode of an all-zero configuration
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= '{ext_clock_used: 1'b1, default: 1'b0};
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign current_code = current_r;
  assign ctrl = ctrl_r;
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign green_pwm_level = green_lvl_r;
  assign blue_pwm_level = blue_lvl_r;
  assign green_pwm_out = green_out_r;
  assign blue_pwm_out = blue_out_r;
  assign seq_tick = slow_tick;
  assign red_program_counter = pc_seq_r;
  assign red_pc_load = pc_load_r;
endmodule : lcr_regs

// ===== verif/lcr_regs_sva.sv
// Checker: port-level properties of the LED register bank
`timescale 1ns/1ns
module lcr_regs_sva
  import lcr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire lcr_pkg::lcr_req_type req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [1:0] red_sequencer_run_control,
  input wire lcr_pkg::lcr_current_type current_code,
  input wire lcr_pkg::lcr_ctrl_type ctrl,
  input wire logic seq_tick,
  input wire logic [3:0] red_program_counter,
  input wire logic red_pc_load
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Copy of write data, so decoded outputs can be tied to their cause
  logic [7:0] wd_q;
  always_ff @(posedge mclk) wd_q <= req.wdata;
  wire cfg_wr = req.wr && req.addr == DRIVER_CONFIGURATION_ADDR;
  wire pc_rd = req.rd && req.addr == RED_PROGRAM_COUNTER_ADDR;

  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_stray_valid: assert property (!req.rd |=> !rvalid)
    else $error("rvalid without read");
  a_pc_read_hold: assert property (
    pc_rd && red_sequencer_run_control != SEQUENCER_RUN_CONTROL_HOLD |=> rdata == 8'h00)
    else $error("counter read outside hold");
  a_pc_high_zero: assert property (pc_rd |=> rdata[7:4] == 4'h0)
    else $error("counter upper bits set");
  a_current_wr: assert property (
    req.wr && req.addr == RED_LED_CURRENT_ADDR |=> current_code.red == wd_q)
    else $error("red current not taken");
  a_pump_decode: assert property (cfg_wr |=>
    ctrl.pump_gain == (wd_q[4:3] == PUMP_GAIN) &&
    ctrl.pump_bypass == (wd_q[4:3] == PUMP_BYPASS))
    else $error("pump decode wrong");
  a_cfg_bits: assert property (cfg_wr |=>
    ctrl.power_saving_enable == wd_q[5] && ctrl.red_supply_select == wd_q[2])
    else $error("config bit wrong");
  a_load_tick: assert property (red_pc_load |-> $past(seq_tick))
    else $error("load without tick");
  a_pc_steady: assert property (
    !red_pc_load |-> $stable(red_program_counter))
    else $error("counter moved without load");
  cover property (cfg_wr);
  cover property (red_pc_load);
  cover property (pc_rd && red_sequencer_run_control != SEQUENCER_RUN_CONTROL_HOLD);
endmodule : lcr_regs_sva

// ===== verif/lcr_host_model.sv
// Host-side bus model: single-byte register writes and reads
`timescale 1ns/1ns
module lcr_host_model
  import lcr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output lcr_pkg::lcr_req_type req
);
  time pc_last = 0;
  initial req = '{1'b0, 1'b0, 8'hff, 8'hff};
  // Counter writes wait out the spacing; closer pairs may be lost
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    if (a == RED_PROGRAM_COUNTER_ADDR) begin
      while ($time - pc_last < 154000) @(negedge mclk);
      pc_last = $time;
    end
    @(negedge mclk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask : write
  // Data is taken in the cycle after the request, where rvalid stands
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    d = rvalid ? rdata : 8'hxx;
    req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask : read
endmodule : lcr_host_model

// ===== verif/test_lcr_regs.sv
// Testbench for the LED register bank, driven through the host model
`timescale 1ns/1ns
module test_lcr_regs;
  import lcr_pkg::*;
  logic mclk = 1'h0, resetn = 1'h0, slow = 1'h0;
  logic [1:0] g_mode = 2'h0, b_mode = 2'h0, run = 2'h0;
  logic [7:0] rdata, g_lvl, b_lvl, v, w;
  logic rvalid, g_out, b_out, tick, load;
  logic [3:0] pc;
  lcr_req_type req;
  lcr_current_type cur;
  lcr_ctrl_type ctrl;
  int n_fail = 0, check_count = 0, hi, lo;
  always #5 mclk = ~mclk;
  // External slow clock runs free, as a crystal would
  always #15259 slow = ~slow;
  lcr_regs #(.INT_DIV(8), .FAST_DIV(4)) dut (.mclk(mclk), .resetn(resetn),
    .req(req), .rdata(rdata), .rvalid(rvalid), .slow_clock_input(slow),
    .green_mode(g_mode), .blue_mode(b_mode),
    .red_sequencer_run_control(run), .green_seq_level(8'h21),
    .blue_seq_level(8'h33), .green_pwm_level(g_lvl), .blue_pwm_level(b_lvl),
    .green_pwm_out(g_out), .blue_pwm_out(b_out), .current_code(cur),
    .ctrl(ctrl), .seq_tick(tick), .red_program_counter(pc),
    .red_pc_load(load));
  lcr_host_model host (.mclk(mclk), .rdata(rdata), .rvalid(rvalid),
    .req(req));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.read(a, v);
    check(v, e);
  endtask : rdchk
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // Watchdog well beyond the expected run of some 31k cycles
  initial begin
    #600000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge mclk);
    resetn = 1;
    // Reset values across the bank
    for (int a = 3; a < 10; a++) begin
      rdchk(a[7:0], a inside {[5:7]} ? 8'haf : 8'h00);
    end
    check(cur.green, 8'haf);
    // Current codes at both ends of the range
    host.write(RED_LED_CURRENT_ADDR, 8'hff);
    host.write(GREEN_LED_CURRENT_ADDR, 8'h00);
    check(cur.red, 8'hff);
    check(cur.green, 8'h00);
    // Every pump and clock source code, unused bit set
    for (int i = 0; i < 4; i++) begin
      w = 8'h80 | 8'(i << 3) | 8'(i);
      host.write(DRIVER_CONFIGURATION_ADDR, w);
      rdchk(DRIVER_CONFIGURATION_ADDR, w & 8'h7f);
      check({4'h0, ctrl[6:3]}, {4'h0, i != 0, i == 1, i == 2, i == 3});
      if (i != 2) check({7'h0, ctrl.ext_clock_used}, {7'h0, i == 0});
      if (i == 2) begin
        // Auto source takes a fresh pin edge, then drops it when four internal ticks pass with no edge
        @(slow);
        repeat (6) @(negedge mclk);
        check({7'h0, ctrl.ext_clock_used}, 8'h01);
        repeat (60) @(negedge mclk);
        check({7'h0, ctrl.ext_clock_used}, 8'h00);
      end
    end
    for (int j = 0; j < 2; j++) begin
      host.write(DRIVER_CONFIGURATION_ADDR, j ? 8'h24 : 8'h00);
      check({6'h0, ctrl[2:1]}, {6'h0, j[0], j[0]});
    end
    // Fast PWM frame: green direct, blue from sequencer
    host.write(DRIVER_CONFIGURATION_ADDR, 8'h41);
    host.write(GREEN_PWM_DUTY_ADDR, 8'h40);
    host.write(BLUE_PWM_DUTY_ADDR, 8'h99);
    g_mode = MODE_DIRECT;
    repeat (2100) @(negedge mclk);
    check(g_lvl, 8'h40);
    check(b_lvl, 8'h33);
    // One frame is 256 steps of 4 cycles, so 4 high cycles per code
    hi = 0;
    lo = 0;
    repeat (1024) @(negedge mclk) begin
      hi += g_out;
      lo += b_out;
    end
    check(8'(hi / 4), 8'h40);
    check(8'(lo / 4), 8'h33);
    // Counter handover in hold, then a refused write
    host.write(RED_PROGRAM_COUNTER_ADDR, 8'hf5);
    hi = 0;
    while (load !== 1'b1 && hi < 100) begin
      @(negedge mclk);
      hi++;
    end
    check({4'h0, pc}, 8'h05);
    rdchk(RED_PROGRAM_COUNTER_ADDR, 8'h05);
    run = 2'b10;
    host.write(RED_PROGRAM_COUNTER_ADDR, 8'h0a);
    rdchk(RED_PROGRAM_COUNTER_ADDR, 8'h00);
    run = SEQUENCER_RUN_CONTROL_HOLD;
    repeat (40) @(negedge mclk);
    check({4'h0, pc}, 8'h05);
    rdchk(RED_PROGRAM_COUNTER_ADDR, 8'h05);
    // Unmapped place reads zero
    host.write(8'h0c, 8'h5a);
    rdchk(8'h0c, 8'h00);
    conclude();
  end
endmodule : test_lcr_regs
bind lcr_regs lcr_regs_sva chk (.mclk(mclk), .resetn(resetn), .req(req),
  .rdata(rdata), .rvalid(rvalid),
  .red_sequencer_run_control(red_sequencer_run_control),
  .current_code(current_code), .ctrl(ctrl), .seq_tick(seq_tick),
  .red_program_counter(red_program_counter), .red_pc_load(red_pc_load));
